// *** src/ext_boot_defs.svh ***
// Constants of the external memory interface and boot loader.
// Assumes a 250 MHz instruction clock; included by bare name.
`ifndef EXT_BOOT_DEFS_SVH
`define EXT_BOOT_DEFS_SVH

// Clock period and external access length
`define CLK_PERIOD_NS 4
`define ACC_LAST 2'd3

// Lane enables on the 24-bit data bus
`define DM_LANES 24'hffff00
`define BOOT_LANES 24'hc00000
`define NO_LANES 24'h000000

// Start addresses
`define SA_ZERO 14'h0000
`define SA_USER 14'h0060
`define SA_MONITOR 14'h0800

// Monitor start-up
`define VEC_LAST 7'h5f
`define MODE_SROM 2'b10
`define MODE_UART 2'b11

// Serial memory clock, 1 Mb/s
`define SROM_BIT_NS 1000
`define SROM_HALF_CYC ((`SROM_BIT_NS / `CLK_PERIOD_NS) / 2)

// Autobaud: the 0x70 byte holds the line low for five bit times
`define AB_LOW_BITS 16'd5
`define HDR_IFACES 3'd6
`define HDR_LAST_BIT 4'd8

// Boot page layout
`define LEN_OFF 13'h0000
`define LAST_OFF 13'h0001
`define GROUP_FIRST 2'b01

`endif

// *** src/ext_boot_pkg.sv ***
// Types of the external memory interface and boot loader.
// Assumes nothing beyond a SystemVerilog compiler.
package ext_boot_pkg;

	typedef enum logic [3:0] {
		S_STRAP = 4'b0000,
		S_VEC = 4'b0001,
		S_FLAG = 4'b0010,
		S_SROM = 4'b0011,
		S_AB_IDLE = 4'b0100,
		S_AB_LOW = 4'b0101,
		S_AB_REST = 4'b0110,
		S_H_WAIT = 4'b0111,
		S_HDR = 4'b1000,
		S_LEN = 4'b1001,
		S_BYTES = 4'b1010,
		S_DRAIN = 4'b1011,
		S_RUN = 4'b1100
	} ctl_e;

	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_PM = 2'b01,
		B_DM = 2'b10,
		B_BOOT = 2'b11
	} bus_e;

	typedef struct packed {
		ctl_e cst;
		bus_e bst;
		logic [1:0] s1_strap;
		logic [1:0] s2_strap;
		logic [1:0] swait;
		logic [23:0] s1_din;
		logic [23:0] s2_din;
		logic s1_rxa;
		logic s2_rxa;
		logic s1_rxb;
		logic s2_rxb;
		logic [1:0] bcnt;
		logic [13:0] addr;
		logic aoe;
		logic [23:0] dout;
		logic [23:0] doe;
		logic pms_n;
		logic dms_n;
		logic bms_n;
		logic rd_n;
		logic wr_n;
		logic acc_done;
		logic [23:0] pm_rdata;
		logic [15:0] dm_rdata;
		logic run;
		logic [13:0] exec;
		logic wait_zero;
		logic [6:0] vcnt;
		logic [1:0] fcnt;
		logic fl1;
		logic fs;
		logic rxsel;
		logic [1:0] mode45;
		logic [6:0] dcnt;
		logic sclk;
		logic [15:0] tcnt;
		logic [15:0] baud;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic [2:0] iface;
		logic iface_valid;
		logic [2:0] page;
		logic [12:0] boff;
		logic [7:0] bbyte;
		logic push;
		logic [1:0] bsel;
		logic [15:0] asm_lo;
		logic [10:0] widx;
		logic pm_valid;
		logic [10:0] pm_addr;
		logic [23:0] pm_data;
	} state_s;

endpackage

// *** src/byte_fifo.sv ***
// Small FIFO with registered read data, valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [CW-1:0] count;
		logic ovalid;
		logic [WIDTH-1:0] odata;
	} fifo_s;

	fifo_s st;
	fifo_s n;
	logic push;
	logic pop;

	// Stored words exclude the one waiting in the output register
	assign in_ready = (st.count != CW'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = (st.count != '0) && (!st.ovalid || out_ready);
	assign out_valid = st.ovalid;
	assign out_data = st.odata;

	// Next state: write, refill the output register, count
	always_comb begin
		n = st;
		if (out_ready) begin
			n.ovalid = 1'b0;
		end
		if (push) begin
			n.mem[st.wptr] = in_data;
			n.wptr = st.wptr + AW'(1);
		end
		if (pop) begin
			n.odata = st.mem[st.rptr];
			n.ovalid = 1'b1;
			n.rptr = st.rptr + AW'(1);
		end
		n.count = st.count + CW'(push) - CW'(pop);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

endmodule

`default_nettype wire

// *** src/ext_memory_boot_loader.sv ***
// External memory interface with strap-selected boot sequencing.
// Assumes pins arrive unsynchronised; core, program RAM and serial port
// logic run on clk. Boot bytes pass a 32-word FIFO to the RAM loader.
`timescale 1ns/100ps
`default_nettype none
`include "ext_boot_defs.svh"

module ext_memory_boot_loader (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Strap pins
	input wire logic memory_map_select,
	input wire logic boot_mode_select,
	// External bus pins
	output logic [13:0] addr_out,
	output logic addr_oe,
	input wire logic [23:0] data_in,
	output logic [23:0] data_out,
	output logic [23:0] data_oe,
	output logic program_memory_select_n,
	output logic data_memory_select_n,
	output logic boot_memory_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	// Core access port
	input wire logic acc_req,
	input wire logic acc_pm_ext,
	input wire logic acc_dm_ext,
	input wire logic acc_dm_write,
	input wire logic [13:0] acc_pm_addr,
	input wire logic [13:0] acc_dm_addr,
	input wire logic [15:0] acc_dm_wdata,
	output logic acc_done,
	output logic [23:0] acc_pm_rdata,
	output logic [15:0] acc_dm_rdata,
	// Boot control and status
	input wire logic boot_force,
	input wire logic [2:0] boot_page_select,
	output logic core_run,
	output logic [13:0] exec_addr,
	output logic dm_wait_zero,
	// Program RAM load port and vector ROM
	output logic pm_load_valid,
	input wire logic pm_load_ready,
	output logic [10:0] pm_load_addr,
	output logic [23:0] pm_load_data,
	output logic [6:0] vec_rom_addr,
	input wire logic [23:0] vec_rom_data,
	// Serial port 1
	input wire logic serial_rx_pin_a,
	input wire logic serial_rx_pin_b,
	output logic serial_rx_input,
	output logic frame_sync_or_serial_mem_reset,
	output logic srom_sclk,
	input wire logic srom_ok,
	input wire logic srom_fail,
	output logic [7:0] mode_control_reg,
	output logic [15:0] baud_period,
	output logic [2:0] iface_select,
	output logic iface_valid
);

	ext_boot_pkg::state_s st;
	ext_boot_pkg::state_s n;
	logic boot_got;
	logic boot_go;
	logic pop;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;

	// Boot fetch completes; a byte fetch may start only with FIFO room, the length fetch without
	assign boot_got = (st.bst == ext_boot_pkg::B_BOOT) && (st.bcnt == `ACC_LAST);
	assign boot_go = (st.bst == ext_boot_pkg::B_IDLE) &&
		((st.cst == ext_boot_pkg::S_LEN) ||
		((st.cst == ext_boot_pkg::S_BYTES) && fifo_in_ready && !st.push));
	assign pop = fifo_out_valid && !st.pm_valid;

	// Boot byte buffer between bus fetch and RAM loader
	byte_fifo #(.WIDTH(8), .DEPTH(32)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(st.push),
		.in_ready(fifo_in_ready),
		.in_data(st.bbyte),
		.out_valid(fifo_out_valid),
		.out_ready(!st.pm_valid),
		.out_data(fifo_out_data)
	);

	// Next state of the whole block
	always_comb begin
		n = st;
		n.acc_done = 1'b0;
		n.push = 1'b0;
		n.s1_strap = {memory_map_select, boot_mode_select};
		n.s2_strap = st.s1_strap;
		n.s1_din = data_in;
		n.s2_din = st.s1_din;
		n.s1_rxa = serial_rx_pin_a;
		n.s2_rxa = st.s1_rxa;
		n.s1_rxb = serial_rx_pin_b;
		n.s2_rxb = st.s1_rxb;
		if (st.pm_valid && pm_load_ready) begin
			n.pm_valid = 1'b0;
		end

		// Bus sequencer; program read precedes data access
		unique case (st.bst)
		ext_boot_pkg::B_IDLE: begin
			n.bcnt = 2'd0;
			if (boot_go) begin
				n.bst = ext_boot_pkg::B_BOOT;
			end else if (st.run && acc_req && !st.acc_done) begin
				if (acc_pm_ext) begin
					n.bst = ext_boot_pkg::B_PM;
				end else if (acc_dm_ext) begin
					n.bst = ext_boot_pkg::B_DM;
				end else begin
					n.acc_done = 1'b1;
				end
			end
		end
		default: begin
			n.bcnt = st.bcnt + 2'd1;
			if (st.bcnt == `ACC_LAST) begin
				n.bcnt = 2'd0;
				n.bst = ext_boot_pkg::B_IDLE;
				if (st.bst == ext_boot_pkg::B_PM) begin
					n.pm_rdata = st.s2_din;
					if (acc_dm_ext) begin
						n.bst = ext_boot_pkg::B_DM;
					end else begin
						n.acc_done = 1'b1;
					end
				end else if (st.bst == ext_boot_pkg::B_DM) begin
					n.dm_rdata = st.s2_din[23:8];
					n.acc_done = 1'b1;
				end else begin
					n.bbyte = st.s2_din[15:8];
				end
			end
		end
		endcase

		// Boot and monitor sequencer
		unique case (st.cst)
		ext_boot_pkg::S_STRAP: begin
			n.swait = st.swait + 2'd1;
			if (st.swait == 2'd3) begin
				if (st.s2_strap == 2'b11) begin
					n.cst = ext_boot_pkg::S_VEC;
					n.exec = `SA_MONITOR;
					n.wait_zero = 1'b1;
				end else if (st.s2_strap == 2'b00) begin
					n.cst = ext_boot_pkg::S_LEN;
					n.page = 3'd0;
					n.boff = `LEN_OFF;
				end else begin
					n.cst = ext_boot_pkg::S_RUN;
					n.run = 1'b1;
				end
			end
		end
		ext_boot_pkg::S_VEC: begin
			if (!st.pm_valid || pm_load_ready) begin
				n.pm_valid = 1'b1;
				n.pm_addr = {4'h0, st.vcnt};
				n.pm_data = vec_rom_data;
				n.vcnt = st.vcnt + 7'd1;
				if (st.vcnt == `VEC_LAST) begin
					n.cst = ext_boot_pkg::S_FLAG;
					n.mode45 = `MODE_SROM;
				end
			end
		end
		ext_boot_pkg::S_FLAG: begin
			n.fl1 = (st.fcnt == 2'd0) ? 1'b1 : !st.fl1;
			n.fcnt = st.fcnt + 2'd1;
			if (st.fcnt == 2'd2) begin
				n.cst = ext_boot_pkg::S_SROM;
			end
		end
		ext_boot_pkg::S_SROM: begin
			n.dcnt = st.dcnt + 7'd1;
			if (st.dcnt == 7'(`SROM_HALF_CYC - 1)) begin
				n.dcnt = 7'd0;
				n.sclk = !st.sclk;
			end
			if (srom_ok) begin
				n.cst = ext_boot_pkg::S_RUN;
				n.run = 1'b1;
				n.exec = `SA_USER;
				n.sclk = 1'b0;
			end else if (srom_fail) begin
				n.cst = ext_boot_pkg::S_AB_IDLE;
				n.mode45 = `MODE_UART;
				n.sclk = 1'b0;
			end
		end
		ext_boot_pkg::S_AB_IDLE: begin
			n.tcnt = 16'd1;
			if (!st.s2_rxb) begin
				n.cst = ext_boot_pkg::S_AB_LOW;
			end
		end
		ext_boot_pkg::S_AB_LOW: begin
			// Start bit plus four zero bits of the autobaud byte
			if (!st.s2_rxb) begin
				n.tcnt = st.tcnt + 16'd1;
			end else begin
				n.baud = st.tcnt / `AB_LOW_BITS;
				n.tcnt = 16'd0;
				n.cst = ext_boot_pkg::S_AB_REST;
			end
		end
		ext_boot_pkg::S_AB_REST: begin
			// Skip three ones, a zero and half the stop bit
			n.tcnt = st.tcnt + 16'd1;
			if ({2'b00, st.tcnt} >=
				({st.baud, 2'b00} + {3'b000, st.baud[15:1]})) begin
				n.cst = ext_boot_pkg::S_H_WAIT;
			end
		end
		ext_boot_pkg::S_H_WAIT: begin
			n.tcnt = 16'd0;
			n.bitn = 4'd0;
			if (!st.s2_rxb) begin
				n.cst = ext_boot_pkg::S_HDR;
			end
		end
		ext_boot_pkg::S_HDR: begin
			n.tcnt = st.tcnt + 16'd1;
			if (st.tcnt == ((st.bitn == 4'd0) ? {1'b0, st.baud[15:1]} :
				st.baud)) begin
				n.tcnt = 16'd0;
				n.bitn = st.bitn + 4'd1;
				if (st.bitn != 4'd0) begin
					n.shreg = {st.s2_rxb, st.shreg[7:1]};
				end
				if (st.bitn == `HDR_LAST_BIT) begin
					if (n.shreg[7:3] == 5'h00 &&
						n.shreg[2:0] < `HDR_IFACES) begin
						n.iface = n.shreg[2:0];
						n.iface_valid = 1'b1;
						n.run = 1'b1;
						n.cst = ext_boot_pkg::S_RUN;
					end else begin
						n.cst = ext_boot_pkg::S_AB_IDLE;
					end
				end
			end
		end
		ext_boot_pkg::S_LEN: begin
			if (boot_got) begin
				// Top byte is 32 per length step plus 31
				n.boff = {st.s2_din[15:8], 5'h1f};
				n.widx = {st.s2_din[15:8], 3'h7};
				n.bsel = 2'd0;
				n.cst = ext_boot_pkg::S_BYTES;
			end
		end
		ext_boot_pkg::S_BYTES: begin
			if (boot_got) begin
				n.push = 1'b1;
				if (st.boff == `LAST_OFF) begin
					n.cst = ext_boot_pkg::S_DRAIN;
				end else if (st.boff[1:0] == `GROUP_FIRST) begin
					n.boff = st.boff - 13'd2;
				end else begin
					n.boff = st.boff - 13'd1;
				end
			end
		end
		ext_boot_pkg::S_DRAIN: begin
			if (!st.push && !fifo_out_valid && !st.pm_valid &&
				st.bsel == 2'd0) begin
				n.cst = ext_boot_pkg::S_RUN;
				n.run = 1'b1;
				n.exec = `SA_ZERO;
			end
		end
		ext_boot_pkg::S_RUN: begin
			if (st.s2_strap == 2'b00 && boot_force && !acc_req &&
				st.bst == ext_boot_pkg::B_IDLE) begin
				n.run = 1'b0;
				n.page = boot_page_select;
				n.boff = `LEN_OFF;
				n.cst = ext_boot_pkg::S_LEN;
			end
		end
		default: begin
			n.cst = ext_boot_pkg::S_STRAP;
		end
		endcase

		// Assemble words, low byte first since bytes arrive top down
		if (pop) begin
			n.asm_lo = {fifo_out_data, st.asm_lo[15:8]};
			n.bsel = st.bsel + 2'd1;
			if (st.bsel == 2'd2) begin
				n.bsel = 2'd0;
				n.pm_valid = 1'b1;
				n.pm_addr = st.widx;
				n.pm_data = {fifo_out_data, st.asm_lo};
				n.widx = st.widx - 11'd1;
			end
		end

		// Routing driven by the mode bits
		n.rxsel = st.mode45[0] ? st.s2_rxb : st.s2_rxa;
		n.fs = n.mode45[1] ? n.fl1 : 1'b0;

		// Pins follow the next bus state; idle leaves all off
		n.pms_n = 1'b1;
		n.dms_n = 1'b1;
		n.bms_n = 1'b1;
		n.rd_n = 1'b1;
		n.wr_n = 1'b1;
		n.aoe = 1'b0;
		n.doe = `NO_LANES;
		unique case (n.bst)
		ext_boot_pkg::B_PM: begin
			n.pms_n = 1'b0;
			n.rd_n = 1'b0;
			n.aoe = 1'b1;
			n.addr = acc_pm_addr;
		end
		ext_boot_pkg::B_DM: begin
			n.dms_n = 1'b0;
			n.aoe = 1'b1;
			n.addr = acc_dm_addr;
			if (acc_dm_write) begin
				n.wr_n = 1'b0;
				n.dout = {acc_dm_wdata, 8'h00};
				n.doe = `DM_LANES;
			end else begin
				n.rd_n = 1'b0;
			end
		end
		ext_boot_pkg::B_BOOT: begin
			n.bms_n = 1'b0;
			n.rd_n = 1'b0;
			n.aoe = 1'b1;
			n.addr = {n.page[0], n.boff};
			n.dout = {n.page[2:1], 22'h000000};
			n.doe = `BOOT_LANES;
		end
		default: begin
		end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.pms_n <= 1'b1;
			st.dms_n <= 1'b1;
			st.bms_n <= 1'b1;
			st.rd_n <= 1'b1;
			st.wr_n <= 1'b1;
		end else begin
			st <= n;
		end
	end

	// Outputs straight from the state register
	assign addr_out = st.addr;
	assign addr_oe = st.aoe;
	assign data_out = st.dout;
	assign data_oe = st.doe;
	assign program_memory_select_n = st.pms_n;
	assign data_memory_select_n = st.dms_n;
	assign boot_memory_select_n = st.bms_n;
	assign read_strobe_n = st.rd_n;
	assign write_strobe_n = st.wr_n;
	assign acc_done = st.acc_done;
	assign acc_pm_rdata = st.pm_rdata;
	assign acc_dm_rdata = st.dm_rdata;
	assign core_run = st.run;
	assign exec_addr = st.exec;
	assign dm_wait_zero = st.wait_zero;
	assign pm_load_valid = st.pm_valid;
	assign pm_load_addr = st.pm_addr;
	assign pm_load_data = st.pm_data;
	assign vec_rom_addr = st.vcnt;
	assign serial_rx_input = st.rxsel;
	assign frame_sync_or_serial_mem_reset = st.fs;
	assign srom_sclk = st.sclk;
	assign mode_control_reg = {2'b00, st.mode45, 4'h0};
	assign baud_period = st.baud;
	assign iface_select = st.iface;
	assign iface_valid = st.iface_valid;

	// Checks on the pins and sequences
	a_strobe_excl: assert property (@(posedge clk) disable iff (!rst_n)
		!(!read_strobe_n && !write_strobe_n) && $onehot0({
		!program_memory_select_n, !data_memory_select_n,
		!boot_memory_select_n}))
		else $error("strobes or selects overlap");
	a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(program_memory_select_n && data_memory_select_n &&
		boot_memory_select_n) |-> (!addr_oe && data_oe == `NO_LANES &&
		read_strobe_n && write_strobe_n))
		else $error("bus driven while no select is low");
	a_dual_order: assert property (@(posedge clk) disable iff (!rst_n)
		($fell(data_memory_select_n) && acc_pm_ext) |->
		$past(!program_memory_select_n))
		else $error("data access did not follow program read");
	a_dm_lanes: assert property (@(posedge clk) disable iff (!rst_n)
		(!data_memory_select_n && !write_strobe_n) |->
		(data_oe == `DM_LANES && data_out[7:0] == 8'h00))
		else $error("data write not on upper lanes");
	a_boot_lanes: assert property (@(posedge clk) disable iff (!rst_n)
		!boot_memory_select_n |-> (data_oe == `BOOT_LANES &&
		!read_strobe_n && addr_oe))
		else $error("boot read lanes wrong");
	a_pm_select: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(program_memory_select_n) |->
		(!program_memory_select_n && !read_strobe_n)[*4] ##1
		program_memory_select_n)
		else $error("program access length wrong");
	a_len_first: assert property (@(posedge clk) disable iff (!rst_n)
		($fell(boot_memory_select_n) && st.cst == ext_boot_pkg::S_LEN)
		|-> addr_out[12:0] == `LEN_OFF)
		else $error("page length not read first");
	a_vec_range: assert property (@(posedge clk) disable iff (!rst_n)
		(pm_load_valid && st.cst == ext_boot_pkg::S_VEC) |->
		(pm_load_addr <= {4'h0, `VEC_LAST} && dm_wait_zero))
		else $error("vector copy out of range");
	a_flag_seq: assert property (@(posedge clk) disable iff (!rst_n)
		(st.cst == ext_boot_pkg::S_FLAG && st.fcnt == 2'd0) |=>
		frame_sync_or_serial_mem_reset ##1 !frame_sync_or_serial_mem_reset
		##1 frame_sync_or_serial_mem_reset)
		else $error("serial memory reset pulse wrong");
	a_user_start: assert property (@(posedge clk) disable iff (!rst_n)
		(st.cst == ext_boot_pkg::S_SROM && srom_ok) |=>
		(exec_addr == `SA_USER && core_run))
		else $error("user code start wrong");
	a_uart_mode: assert property (@(posedge clk) disable iff (!rst_n)
		(st.cst == ext_boot_pkg::S_SROM && !srom_ok && srom_fail) |=>
		(mode_control_reg[5:4] == `MODE_UART &&
		st.cst == ext_boot_pkg::S_AB_IDLE))
		else $error("fallback to UART wrong");

endmodule

`default_nettype wire

// *** tb/ext_mem_model.sv ***
// Far side model: external program and data memory plus boot EPROM.
// Assumes registered selects, strobes and buses from the device on clk.
`timescale 1ns/100ps
`default_nettype none

module ext_mem_model (
	// Clock and device pins
	input wire logic clk,
	input wire logic [13:0] a,
	input wire logic [23:0] dout,
	input wire logic [23:0] doe,
	input wire logic pms_n,
	input wire logic dms_n,
	input wire logic bms_n,
	input wire logic rd_n,
	input wire logic wr_n,
	// Resolved bus level
	output logic [23:0] din
);
	logic [23:0] pm [0:16383];
	logic [15:0] dm [0:16383];
	logic [23:0] last = 24'h000000;
	logic [23:0] drv;
	logic bq = 1'b1;
	int cyc = 0, n_sel = 0, n_boot = 0, t_pm = 0, t_dm = 0;

	// Boot byte: page length at offset 0, a pattern elsewhere
	function automatic logic [7:0] rom(input logic [15:0] x);
		if (x[12:0] == 13'h0000)
			return {7'h00, x[13]};
		return x[7:0] ^ {x[15:13], 5'h00};
	endfunction

	// Memory contents at time zero
	initial begin
		for (int i = 0; i < 16384; i++) begin
			pm[i] = {i[11:0], ~i[11:0]};
			dm[i] = {i[7:0], 8'h3c};
		end
	end

	// A selected read drives the lines; idle lines toggle every cycle
	always_comb begin
		drv = ~last;
		if (!rd_n && !pms_n)
			drv = pm[a];
		else if (!rd_n && !dms_n)
			drv = {dm[a], ~last[7:0]};
		else if (!rd_n && !bms_n)
			drv = {~last[23:16], rom({dout[23:22], a}), ~last[7:0]};
	end
	assign din = (doe & dout) | (~doe & drv);

	// Writes and bus history for the bench
	always @(posedge clk) begin
		last <= din;
		bq <= bms_n;
		cyc <= cyc + 1;
		if (!wr_n && !dms_n)
			dm[a] <= dout[23:8];
		if (!pms_n || !dms_n)
			n_sel <= n_sel + 1;
		if (!pms_n)
			t_pm <= cyc;
		if (!dms_n)
			t_dm <= cyc;
		if (bq && !bms_n)
			n_boot <= n_boot + 1;
	end

endmodule
`default_nettype wire

// *** tb/test_ext_memory_boot_loader.sv ***
// Self-checking bench for the external memory interface and boot loader.
// Assumes ext_mem_model on the far side and a 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module test_ext_memory_boot_loader;
	// Design pins
	logic clk, rst_n, memory_map_select, boot_mode_select, addr_oe;
	logic program_memory_select_n, data_memory_select_n, read_strobe_n;
	logic boot_memory_select_n, write_strobe_n, acc_req, acc_pm_ext;
	logic acc_dm_ext, acc_dm_write, acc_done, boot_force, core_run;
	logic dm_wait_zero, pm_load_valid, pm_load_ready, serial_rx_pin_a;
	logic serial_rx_pin_b, serial_rx_input, srom_sclk, srom_ok;
	logic srom_fail, iface_valid, frame_sync_or_serial_mem_reset;
	logic [13:0] addr_out, acc_pm_addr, acc_dm_addr, exec_addr;
	logic [23:0] data_in, data_out, data_oe, acc_pm_rdata;
	logic [23:0] pm_load_data, vec_rom_data;
	logic [15:0] acc_dm_wdata, acc_dm_rdata, baud_period;
	logic [10:0] pm_load_addr;
	logic [7:0] mode_control_reg;
	logic [6:0] vec_rom_addr;
	logic [2:0] boot_page_select, iface_select, pg;
	// Bench state
	int n_mismatch = 0, n_checks = 0, i, h, per, wexp, nw, vexp, fs_rise;
	logic [31:0] seed = 32'h023f, rs = 32'h023f;
	logic vmode, stall = 1'b0;
	logic [15:0] shadow [int];

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] eprom(input logic [15:0] x);
		if (x[12:0] == 13'h0000)
			return {7'h00, x[13]};
		return x[7:0] ^ {x[15:13], 5'h00};
	endfunction

	// Word k of a page: bytes 4k+1, 4k+2, 4k+3 from high to low
	function automatic logic [23:0] bword(input logic [2:0] p, input int k);
		logic [15:0] x;
		x = {p, 13'(4 * k)};
		return {eprom(x + 16'h1), eprom(x + 16'h2), eprom(x + 16'h3)};
	endfunction

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [23:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic need(input logic ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch wait expected 1 seen %b", ok);
			summarize();
		end
	endtask

	task automatic do_reset(input logic [1:0] s);
		rst_n = 1'b0;
		{memory_map_select, boot_mode_select} = s;
		vmode = s[0];
		pg = 3'h0;
		wexp = 7;
		nw = 0;
		vexp = 0;
		fs_rise = 0;
		repeat (20) tick();
		rst_n = 1'b1;
	endtask

	// One asynchronous frame, LSB first, then two idle bit times
	task automatic send(input logic [7:0] b, input int p);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int j = 0; j < 10; j++) begin
			serial_rx_pin_b = f[j];
			repeat (p) tick();
		end
		repeat (2 * p) tick();
	endtask

	// One core access: latency, select cycles, order and data
	task automatic access(input logic p, d, w, input logic [13:0] pa, da);
		int n0, lat, k;
		logic [15:0] ed;
		ed = shadow.exists(da) ? shadow[da] : {da[7:0], 8'h3c};
		n0 = mem.n_sel;
		k = int'(p) + int'(d);
		{acc_req, acc_pm_ext, acc_dm_ext, acc_dm_write} = {1'b1, p, d, w};
		{acc_pm_addr, acc_dm_addr, acc_dm_wdata} = {pa, da, seed[31:16]};
		for (lat = 0; lat < 40 && acc_done !== 1'b1; lat++)
			tick();
		chk("latency", 24'(4 * k + 1), 24'(lat));
		chk("sel_cycles", 24'(n0 + 4 * k), 24'(mem.n_sel));
		if (p)
			chk("pm_rdata", {pa[11:0], ~pa[11:0]}, acc_pm_rdata);
		if (d && !w)
			chk("dm_rdata", 24'(ed), 24'(acc_dm_rdata));
		if (p && d)
			chk("order", 24'h1, 24'(mem.t_pm < mem.t_dm));
		if (d && w)
			shadow[da] = seed[31:16];
		tick();
		acc_req = 1'b0;
		tick();
	endtask

	ext_memory_boot_loader dut (.clk, .rst_n, .memory_map_select,
		.boot_mode_select, .addr_out, .addr_oe, .data_in,
		.data_out, .data_oe, .program_memory_select_n,
		.data_memory_select_n, .boot_memory_select_n,
		.read_strobe_n, .write_strobe_n, .acc_req, .acc_pm_ext,
		.acc_dm_ext, .acc_dm_write, .acc_pm_addr, .acc_dm_addr,
		.acc_dm_wdata, .acc_done, .acc_pm_rdata, .acc_dm_rdata,
		.boot_force, .boot_page_select, .core_run, .exec_addr,
		.dm_wait_zero, .pm_load_valid, .pm_load_ready,
		.pm_load_addr, .pm_load_data, .vec_rom_addr,
		.vec_rom_data, .serial_rx_pin_a, .serial_rx_pin_b,
		.serial_rx_input, .frame_sync_or_serial_mem_reset,
		.srom_sclk, .srom_ok, .srom_fail, .mode_control_reg,
		.baud_period, .iface_select, .iface_valid);

	ext_mem_model mem (.clk(clk), .a(addr_out), .dout(data_out),
		.doe(data_oe), .pms_n(program_memory_select_n),
		.dms_n(data_memory_select_n), .bms_n(boot_memory_select_n),
		.rd_n(read_strobe_n), .wr_n(write_strobe_n), .din(data_in));

	assign vec_rom_data = {1'b0, vec_rom_addr, 8'ha5, 1'b1, vec_rom_addr};

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Random ready on the program RAM port, held low while stalling
	always @(posedge clk) begin
		#1;
		rs = lfsr(rs);
		pm_load_ready = !stall && rs[0];
	end

	// Watch program RAM writes and frame-sync pulses
	always @(posedge clk) begin
		if ($rose(frame_sync_or_serial_mem_reset))
			fs_rise++;
		if (rst_n && pm_load_valid && pm_load_ready) begin
			if (vmode) begin
				chk("vec_addr", 24'(vexp), 24'(pm_load_addr));
				chk("vec_data", {1'b0, 7'(vexp), 8'ha5, 1'b1, 7'(vexp)},
					pm_load_data);
				vexp++;
			end else begin
				chk("boot_addr", 24'(wexp), 24'(pm_load_addr));
				chk("boot_data", bword(pg, wexp), pm_load_data);
				wexp--;
			end
			nw++;
		end
	end

	initial begin
		{acc_req, acc_pm_ext, acc_dm_ext, acc_dm_write, boot_force} = '0;
		{acc_pm_addr, acc_dm_addr, acc_dm_wdata, boot_page_select} = '0;
		{serial_rx_pin_a, serial_rx_pin_b, srom_ok, srom_fail} = 4'hc;
		pm_load_ready = 1'b0;
		// Parallel boot of page 0, then random core accesses
		do_reset(2'b00);
		for (i = 0; i < 3000 && core_run !== 1'b1; i++)
			tick();
		need(core_run);
		chk("boot_words", 24'h8, 24'(nw));
		chk("exec", 24'h0, 24'(exec_addr));
		for (i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			access(seed[0], seed[1], seed[2], seed[16:3], {11'h0, seed[19:17]});
		end
		// Software boot of a random odd page while the RAM port stalls
		seed = lfsr(seed);
		pg = {seed[2:1], 1'b1};
		wexp = 15;
		nw = 0;
		h = mem.n_boot;
		boot_page_select = pg;
		stall = 1'b1;
		boot_force = 1'b1;
		repeat (8) tick();
		boot_force = 1'b0;
		repeat (600) tick();
		chk("stalled", 24'h1, 24'(mem.n_boot - h < 40));
		stall = 1'b0;
		for (i = 0; i < 4000 && nw < 16; i++)
			tick();
		chk("force_words", 24'd16, 24'(nw));
		// Standalone start, serial memory fails, every header code
		for (h = 0; h < 6; h++) begin
			do_reset(2'b11);
			for (i = 0; i < 1000 && mode_control_reg !== 8'h20; i++)
				tick();
			need(mode_control_reg === 8'h20);
			// The last vector write may still wait for ready
			for (i = 0; i < 50 && nw < 96; i++)
				tick();
			chk("vectors", 24'd96, 24'(nw));
			chk("exec", 24'h800, 24'(exec_addr));
			chk("wait_zero", 24'h1, 24'(dm_wait_zero));
			serial_rx_pin_a = 1'b0;
			repeat (8) tick();
			chk("fs_pulses", 24'h2, 24'(fs_rise));
			chk("rx_route", 24'h0, 24'(serial_rx_input));
			serial_rx_pin_a = 1'b1;
			for (i = 0; i < 300 && srom_sclk !== 1'b0; i++)
				tick();
			for (i = 0; i < 300 && srom_sclk !== 1'b1; i++)
				tick();
			for (i = 0; i < 300 && srom_sclk === 1'b1; i++)
				tick();
			chk("sclk_half", 24'd125, 24'(i));
			srom_fail = 1'b1;
			tick();
			srom_fail = 1'b0;
			for (i = 0; i < 50 && mode_control_reg !== 8'h30; i++)
				tick();
			need(mode_control_reg === 8'h30);
			seed = lfsr(seed);
			per = 100 + int'(seed[4:0]);
			send(8'h70, per);
			chk("baud", 24'(per), 24'(baud_period));
			if (h == 0) begin
				send(8'hc3, per);
				chk("bad_hdr", 24'h0, 24'(iface_valid));
				send(8'h70, per);
			end
			send(8'(h), per);
			chk("iface", 24'(h + 8), {20'h0, iface_valid, iface_select});
			chk("run", 24'h1, 24'(core_run));
		end
		// Standalone start, serial memory boot succeeds
		do_reset(2'b11);
		for (i = 0; i < 1000 && srom_sclk !== 1'b1; i++)
			tick();
		need(srom_sclk);
		srom_ok = 1'b1;
		tick();
		srom_ok = 1'b0;
		for (i = 0; i < 50 && core_run !== 1'b1; i++)
			tick();
		need(core_run);
		chk("exec", 24'h60, 24'(exec_addr));
		// External memory mode: no boot fetch, run from 0x0000
		h = mem.n_boot;
		do_reset(2'b10);
		for (i = 0; i < 50 && core_run !== 1'b1; i++)
			tick();
		need(core_run);
		chk("no_boot", 24'(h), 24'(mem.n_boot));
		chk("ext_exec", 24'h0, 24'(exec_addr));
		summarize();
	end

endmodule
`default_nettype wire
